// file: design/fsr_pkg.sv
// Package of constants for the flash status register one block
package fsr_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [3:0] OFF_STATUS_V = 4'h0;
    localparam logic [3:0] OFF_STATUS_N = 4'h1;
    localparam logic [3:0] OFF_CMD = 4'h2;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h3;
    localparam logic [3:0] OFF_IRQ_ENABLE = 4'h4;
    localparam logic [3:0] OFF_IRQ_CLEAR = 4'h5;
    // Status one field positions
    localparam int BIT_BUSY = 0;
    localparam int BIT_PERMIT = 1;
    localparam int BIT_ERASE_FAIL = 5;
    localparam int BIT_PROG_FAIL = 6;
    // Command codes written to the command register
    localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h30;
    localparam logic [7:0] CMD_PERMIT = 8'h06;
    localparam logic [7:0] CMD_PERMIT_VOLATILE = 8'h50;
    localparam logic [7:0] CMD_FORBID = 8'h04;
    localparam logic [7:0] CMD_SOFT_RESET = 8'h99;
    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_PROG_FAIL = 1;
    localparam int IRQ_ERASE_FAIL = 2;
    localparam int IRQ_REFUSED = 3;
    localparam int IRQ_W = 4;
    // Reset values
    localparam logic [7:0] STATUS_N_RESET = 8'h00;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [3:0] ZERO4 = 4'h0;
    // Operation kinds
    typedef enum logic [1:0] {
        FSR_OP_PROGRAM,
        FSR_OP_ERASE,
        FSR_OP_REGWRITE
    } fsr_op_t;
endpackage

// file: design/fsr_status_one.sv
// Status register one of a serial flash in single-lane mode
// Function
// - A failed program operation sets the program failure flag, a good one leaves it clear.
// - A program attempt into a protected region sets the program failure flag.
// - Both failure flags clear only by the clear-flags command or a hardware or software reset.
// - A failed erase operation sets the erase failure flag, a good one leaves it clear.
// - An erase attempt into a protected sector sets the erase failure flag.
// - While a failure flag is set busy stays one and new operations are refused.
// - Failure flags change only while busy is set for the embedded operation; the code also sets them on a protected attempt while busy is zero.
// - Program, erase or register write runs only while the write permit flag is one.
// - Both permit-writes commands set the write permit flag.
// - The forbid-writes command clears the write permit flag.
// - A successful program, erase or register write clears the write permit flag; the code keeps it set when a permit-writes command comes in the same cycle.
// - Power-up and hardware or software reset clear the write permit flag.
// - Busy reads one during an embedded operation and zero in standby.
// - Reserved bits seven and four to two read as zero.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module fsr_status_one
    import fsr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic [fsr_pkg::ADDR_W-1:0] addr_in,
    input wire logic [fsr_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic op_req_in,
    input wire fsr_pkg::fsr_op_t op_kind_in,
    input wire logic op_protected_in,
    input wire logic op_done_in,
    input wire logic op_fail_in,
    output logic [fsr_pkg::DATA_W-1:0] rdata_out,
    output logic op_start_out,
    output logic busy_out,
    output logic irq_out
);
    import fsr_pkg::*;

    logic program_fail_flag_ff;
    logic erase_fail_flag_ff;
    logic write_permit_flag_ff;
    logic op_run_ff;
    fsr_op_t op_kind_ff;
    logic [IRQ_W-1:0] irq_status_ff;
    logic [IRQ_W-1:0] irq_enable_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic op_start_ff;
    logic busy_ff;
    logic irq_ff;

    logic cmd_wr;
    logic clear_cmd;
    logic soft_reset;
    logic any_fail;
    logic accept;
    logic refuse;
    logic fail_prog;
    logic fail_erase;
    logic done_ok;
    logic [IRQ_W-1:0] irq_set;
    logic [DATA_W-1:0] status_v;
    logic [DATA_W-1:0] rd_value;

    logic permit_cmd;
    logic forbid_cmd;
    logic clear_flags;
    logic irq_clear_wr;
    logic irq_enable_wr;

    logic start_op;
    logic prot_hit;
    logic end_fail;
    logic busy_run;
    logic busy_halt;

    // Pure compares; strobe qualification stays outside so every input is seen
    function automatic logic is_cmd(input logic [DATA_W-1:0] code, input logic [DATA_W-1:0] c);
        return code == c;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
        return addr == off;
    endfunction

    function automatic logic [DATA_W-1:0] pad_irq(input logic [IRQ_W-1:0] bits);
        return {ZERO4, bits};
    endfunction

    // Command register decode
    assign cmd_wr = wr_in && hit(addr_in, OFF_CMD);
    assign clear_cmd = cmd_wr && is_cmd(wdata_in, CMD_CLEAR_FLAGS);
    assign soft_reset = cmd_wr && is_cmd(wdata_in, CMD_SOFT_RESET);
    assign permit_cmd = cmd_wr
        && (is_cmd(wdata_in, CMD_PERMIT) || is_cmd(wdata_in, CMD_PERMIT_VOLATILE));
    assign forbid_cmd = cmd_wr && is_cmd(wdata_in, CMD_FORBID);
    assign clear_flags = clear_cmd || soft_reset;

    // Interrupt register decode
    assign irq_clear_wr = wr_in && hit(addr_in, OFF_IRQ_CLEAR);
    assign irq_enable_wr = wr_in && hit(addr_in, OFF_IRQ_ENABLE);

    // Refused while busy or halted on a failure
    assign any_fail = program_fail_flag_ff || erase_fail_flag_ff;
    assign accept = op_req_in && !op_run_ff && !any_fail && write_permit_flag_ff;
    assign refuse = op_req_in && !accept;
    // Protection hits are judged at request time, permit still required
    assign start_op = accept && !op_protected_in;
    assign prot_hit = accept && op_protected_in;
    // Only an engine end inside a running operation, or a protection hit, may raise a flag
    assign end_fail = op_run_ff && op_done_in && op_fail_in;
    assign fail_prog = (prot_hit && op_kind_in == FSR_OP_PROGRAM)
        || (end_fail && op_kind_ff == FSR_OP_PROGRAM);
    assign fail_erase = (prot_hit && op_kind_in == FSR_OP_ERASE)
        || (end_fail && op_kind_ff == FSR_OP_ERASE);
    // Register write failures raise neither flag
    assign done_ok = op_run_ff && op_done_in && !op_fail_in;

    // Running until the engine ends; a soft reset abandons the operation
    assign busy_run = (op_run_ff && !op_done_in && !soft_reset) || start_op;
    // Halted on a failure until cleared; a fresh failure keeps it halted
    assign busy_halt = (any_fail && !clear_flags) || fail_prog || fail_erase;

    // Program failure flag; a new failure beats a clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            program_fail_flag_ff <= 1'b0;
        end else if (clk_en_in) begin
            if (fail_prog) begin
                program_fail_flag_ff <= 1'b1;
            end else if (clear_flags) begin
                program_fail_flag_ff <= 1'b0;
            end
        end
    end

    // Erase failure flag; same priority as the program flag
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            erase_fail_flag_ff <= 1'b0;
        end else if (clk_en_in) begin
            if (fail_erase) begin
                erase_fail_flag_ff <= 1'b1;
            end else if (clear_flags) begin
                erase_fail_flag_ff <= 1'b0;
            end
        end
    end

    // Write permit flag
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            write_permit_flag_ff <= 1'b0;
        end else if (clk_en_in) begin
            if (soft_reset) begin
                write_permit_flag_ff <= 1'b0;
            end else if (permit_cmd) begin
                write_permit_flag_ff <= 1'b1;
            end else if (forbid_cmd) begin
                write_permit_flag_ff <= 1'b0;
            end else if (done_ok) begin
                write_permit_flag_ff <= 1'b0;
            end
        end
    end

    // Engine start pulse; protected attempts never start the engine
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            op_start_ff <= 1'b0;
        end else if (clk_en_in) begin
            op_start_ff <= start_op;
        end
    end

    // Running operation
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            op_run_ff <= 1'b0;
        end else if (clk_en_in) begin
            if (start_op) begin
                op_run_ff <= 1'b1;
            end else if (op_done_in || soft_reset) begin
                op_run_ff <= 1'b0;
            end
        end
    end

    // Kind of the running operation, kept to route its failure
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            op_kind_ff <= FSR_OP_PROGRAM;
        end else if (clk_en_in) begin
            if (start_op) begin
                op_kind_ff <= op_kind_in;
            end
        end
    end

    // Busy covers running and failure-halted states; a request without the write permit flag is refused and does not raise busy
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            busy_ff <= 1'b0;
        end else if (clk_en_in) begin
            busy_ff <= busy_run || busy_halt;
        end
    end

    always_comb begin
        status_v = ZERO8;
        status_v[BIT_PROG_FAIL] = program_fail_flag_ff;
        status_v[BIT_ERASE_FAIL] = erase_fail_flag_ff;
        status_v[BIT_PERMIT] = write_permit_flag_ff;
        status_v[BIT_BUSY] = busy_ff;
    end

    // Read decode; unmapped and write-only offsets read as zero
    always_comb begin
        rd_value = ZERO8;
        if (hit(addr_in, OFF_STATUS_V)) begin
            rd_value = status_v;
        end else if (hit(addr_in, OFF_STATUS_N)) begin
            rd_value = STATUS_N_RESET;
        end else if (hit(addr_in, OFF_IRQ_STATUS)) begin
            rd_value = pad_irq(irq_status_ff);
        end else if (hit(addr_in, OFF_IRQ_ENABLE)) begin
            rd_value = pad_irq(irq_enable_ff);
        end
    end

    // Reads are always served, busy or not; data stands one cycle only
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_ff <= ZERO8;
        end else if (clk_en_in) begin
            if (rd_in) begin
                rdata_ff <= rd_value;
            end else begin
                rdata_ff <= ZERO8;
            end
        end
    end

    always_comb begin
        irq_set = ZERO4;
        irq_set[IRQ_DONE] = done_ok;
        irq_set[IRQ_PROG_FAIL] = fail_prog;
        irq_set[IRQ_ERASE_FAIL] = fail_erase;
        irq_set[IRQ_REFUSED] = refuse;
    end

    // Sticky events; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_status_ff <= ZERO4;
        end else if (clk_en_in) begin
            if (irq_clear_wr) begin
                irq_status_ff <= (irq_status_ff & ~wdata_in[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_status_ff <= irq_status_ff | irq_set;
            end
        end
    end

    // Interrupt enable mask, same layout as the status
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_enable_ff <= ZERO4;
        end else if (clk_en_in) begin
            if (irq_enable_wr) begin
                irq_enable_ff <= wdata_in[IRQ_W-1:0];
            end
        end
    end

    // Level output, one cycle behind status and mask to keep it a flop
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_ff <= 1'b0;
        end else if (clk_en_in) begin
            irq_ff <= |(irq_status_ff & irq_enable_ff);
        end
    end

    assign rdata_out = rdata_ff;
    assign op_start_out = op_start_ff;
    assign busy_out = busy_ff;
    assign irq_out = irq_ff;
endmodule

// file: sim/fsr_engine_model.sv
// Behavioural program and erase engine answering accepted operations
`timescale 1ns/1ps
module fsr_engine_model (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic fail_sel_in,
    input wire logic [3:0] delay_in,
    output logic done_out,
    output logic fail_out
);
    initial begin
        done_out = 1'b0;
        fail_out = 1'b1;
    end
    // Fail line is inverted outside done so no stale value passes
    always begin
        @(posedge clk_in);
        if (start_in === 1'b1) begin
            repeat (delay_in) @(posedge clk_in);
            done_out <= 1'b1;
            fail_out <= fail_sel_in;
            @(posedge clk_in);
            done_out <= 1'b0;
            fail_out <= ~fail_sel_in;
        end
    end
endmodule

// file: sim/fsr_status_one_monitor.sv
// Checker of status register one port behaviour
`timescale 1ns/1ps
module fsr_status_one_monitor
    import fsr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [fsr_pkg::ADDR_W-1:0] addr_in,
    input wire logic rd_in,
    input wire logic op_req_in,
    input wire logic op_done_in,
    input wire logic op_fail_in,
    input wire logic [fsr_pkg::DATA_W-1:0] rdata_out,
    input wire logic op_start_out,
    input wire logic busy_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    chk_start_from_req: assert property (op_start_out |-> $past(op_req_in))
        else $error("start without request");
    chk_start_sets_busy: assert property (op_start_out |-> busy_out)
        else $error("start without busy");
    chk_busy_refuses: assert property (op_req_in && busy_out |=> !op_start_out)
        else $error("start while busy");
    chk_busy_rise_cause: assert property ($rose(busy_out) |-> $past(op_req_in))
        else $error("busy rose without request");
    chk_good_done_idle: assert property (busy_out && op_done_in && !op_fail_in |=> !busy_out)
        else $error("busy kept after good end");
    chk_fail_holds_busy: assert property (busy_out && op_done_in && op_fail_in |=> busy_out[*2])
        else $error("busy dropped after failure");
    chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside read slot");
    chk_reserved_zero: assert property ($past(rd_in) && $past(addr_in) == OFF_STATUS_V
        |-> rdata_out[7] == 1'h0 && rdata_out[4:2] == 3'h0)
        else $error("reserved bits not zero");
    chk_poll_busy: assert property ($past(rd_in) && $past(addr_in) == OFF_STATUS_V
        |-> rdata_out[BIT_BUSY] == $past(busy_out))
        else $error("busy bit differs from busy");
    cover property (op_start_out);
    cover property (busy_out && op_done_in && op_fail_in);
    cover property ($rose(busy_out) && !op_start_out);
endmodule

// file: sim/tb_top.sv
// Testbench for status register one
`timescale 1ns/1ps
module tb_top;
    import fsr_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, op_req_in = 1'b0;
    logic prot = 1'b0, fail_sel = 1'b0, op_start_out, busy_out, irq_out, done, fail;
    logic [3:0] addr_in = 4'h0, dly = 4'h6;
    logic [7:0] wdata_in = 8'h00, rdata_out;
    fsr_op_t kind = FSR_OP_PROGRAM;
    int num_errors = 0, compares = 0, cycles = 0;
    always #12.5 clk_in = ~clk_in;
    fsr_status_one i_dut (.clk_in(clk_in), .rst_in(rst_in), .clk_en_in(1'b1), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .op_req_in(op_req_in),
        .op_kind_in(kind), .op_protected_in(prot), .op_done_in(done), .op_fail_in(fail),
        .rdata_out(rdata_out), .op_start_out(op_start_out), .busy_out(busy_out), .irq_out(irq_out));
    fsr_engine_model i_eng (.clk_in(clk_in), .start_in(op_start_out), .fail_sel_in(fail_sel),
        .delay_in(dly), .done_out(done), .fail_out(fail));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 check(rdata_out, exp);
    endtask
    // Request, expected start, then status once the engine has answered
    task automatic op(input fsr_op_t k, input logic p, f, g, input logic [7:0] s);
        logic go;
        @(posedge clk_in);
        op_req_in <= 1'b1;
        kind <= k;
        prot <= p;
        fail_sel <= f;
        @(posedge clk_in);
        op_req_in <= 1'b0;
        #1 go = op_start_out;
        check({7'h00, go}, {7'h00, g});
        if (go && dly > 4'h2) rdc(OFF_STATUS_V, 8'h03);
        repeat (20) if (go && done !== 1'b1) @(posedge clk_in) #1;
        rdc(OFF_STATUS_V, s);
        check({7'h00, busy_out}, {7'h00, s[BIT_BUSY]});
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        rdc(OFF_STATUS_V, 8'h00);
        rdc(OFF_STATUS_N, 8'h00);
        op(FSR_OP_PROGRAM, 1'b0, 1'b0, 1'b0, 8'h00);
        rdc(OFF_IRQ_STATUS, 8'h08);
        check({7'h00, irq_out}, 8'h00);
        wr(OFF_IRQ_ENABLE, 8'h0F);
        repeat (2) @(posedge clk_in);
        #1 check({7'h00, irq_out}, 8'h01);
        wr(OFF_IRQ_CLEAR, 8'h0F);
        repeat (2) @(posedge clk_in);
        #1 check({7'h00, irq_out}, 8'h00);
        wr(OFF_CMD, CMD_PERMIT);
        rdc(OFF_STATUS_V, 8'h02);
        wr(OFF_CMD, CMD_FORBID);
        rdc(OFF_STATUS_V, 8'h00);
        wr(OFF_CMD, CMD_PERMIT_VOLATILE);
        rdc(OFF_STATUS_V, 8'h02);
        wr(4'hF, 8'hFF);
        rdc(4'hF, 8'h00);
        for (int i = 0; i < 6; i++) begin
            dly <= (i < 3) ? 4'h6 : 4'h0;
            wr(OFF_CMD, CMD_PERMIT);
            op(fsr_op_t'(i % 3), 1'b0, 1'b0, 1'b1, 8'h00);
        end
        for (int i = 0; i < 2; i++) begin
            wr(OFF_CMD, CMD_PERMIT);
            op(fsr_op_t'(i), 1'b0, 1'b1, 1'b1, i ? 8'h23 : 8'h43);
            op(fsr_op_t'(i), 1'b0, 1'b0, 1'b0, i ? 8'h23 : 8'h43);
            wr(OFF_CMD, CMD_CLEAR_FLAGS);
            rdc(OFF_STATUS_V, 8'h02);
            op(fsr_op_t'(i), 1'b1, 1'b0, 1'b0, i ? 8'h23 : 8'h43);
            wr(OFF_CMD, CMD_SOFT_RESET);
            rdc(OFF_STATUS_V, 8'h00);
        end
        conclude();
    end
endmodule
bind fsr_status_one fsr_status_one_monitor i_mon (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .rd_in(rd_in), .op_req_in(op_req_in), .op_done_in(op_done_in),
    .op_fail_in(op_fail_in), .rdata_out(rdata_out), .op_start_out(op_start_out),
    .busy_out(busy_out));
